// >>> include/shift_irq_pkg.sv
// constants for the serial shift register and interrupt logic
package shift_irq_pkg;
  // ----------------------------------------
  // register select codes
  // ----------------------------------------
  localparam logic [3:0] REG_TIMER_LATCH = 4'h8;
  localparam logic [3:0] REG_SHIFT = 4'hA;
  localparam logic [3:0] REG_AUX_CONTROL = 4'hB;
  localparam logic [3:0] REG_FLAGS = 4'hD;
  localparam logic [3:0] REG_ENABLES = 4'hE;
  // ----------------------------------------
  // field layout and reset values
  // ----------------------------------------
  localparam int MODE_LSB = 2;
  localparam int MODE_MSB = 4;
  localparam int SHIFT_FLAG_BIT = 2;
  localparam int SUMMARY_BIT = 7;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  localparam logic [6:0] ENABLES_RESET = 7'h00;
  // ----------------------------------------
  // shift modes
  // ----------------------------------------
  localparam logic [2:0] MODE_DISABLED = 3'h0;
  localparam logic [2:0] MODE_IN_TIMER = 3'h1;
  localparam logic [2:0] MODE_IN_SYSCLK = 3'h2;
  localparam logic [2:0] MODE_IN_EXT = 3'h3;
  localparam logic [2:0] MODE_OUT_FREE = 3'h4;
  localparam logic [2:0] MODE_OUT_TIMER = 3'h5;
  localparam logic [2:0] MODE_OUT_SYSCLK = 3'h6;
  localparam logic [2:0] MODE_OUT_EXT = 3'h7;
  // ----------------------------------------
  // timing counts
  // ----------------------------------------
  localparam logic [8:0] TIMER_EXTRA = 9'h002;
  localparam logic [8:0] SYSCLK_HALF = 9'h001;
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

// >>> include/flag_if.sv
// flag and enable signals between shift logic and flag registers
interface flag_if;
  logic [6:0] set_vec;
  logic [6:0] clear_vec;
  logic wr_enables;
  logic [7:0] wdata;
  logic [6:0] flags;
  logic [6:0] enables;
  logic irq_any;
  modport source (output set_vec, output clear_vec, output wr_enables, output wdata,
                  input flags, input enables, input irq_any);
  modport regs (input set_vec, input clear_vec, input wr_enables, input wdata,
                output flags, output enables, output irq_any);
endinterface

// >>> logic/irq_flag_regs.sv
// interrupt flag and enable registers
module irq_flag_regs (
  input wire logic i_clk,
  input wire logic i_reset,
  flag_if.regs bus
);
  // ----------------------------------------
  // flags and enables
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.flags <= shift_irq_pkg::FLAGS_RESET;
    end else begin
      bus.flags <= (bus.flags & ~bus.clear_vec) | bus.set_vec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus.enables <= shift_irq_pkg::ENABLES_RESET;
    end else if (bus.wr_enables) begin
      if (bus.wdata[shift_irq_pkg::SUMMARY_BIT]) begin
        bus.enables <= bus.enables | bus.wdata[6:0];
      end else begin
        bus.enables <= bus.enables & ~bus.wdata[6:0];
      end
    end
  end

  assign bus.irq_any = |(bus.flags & bus.enables);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_flag_write_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus.clear_vec[0] && !bus.set_vec[0]) |=> !bus.flags[0])
    else $error("flag not cleared by write of one");
  a_enable_set: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus.wr_enables && bus.wdata[7] && bus.wdata[1]) |=> bus.enables[1])
    else $error("enable bit not set");
  a_enable_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus.wr_enables && !bus.wdata[7]) |=> ((bus.enables & $past(bus.wdata[6:0])) == 7'h00))
    else $error("enable bit not cleared");
  a_enable_keep: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus.wr_enables && bus.wdata[6:0] == 7'h00) |=> $stable(bus.enables))
    else $error("enable changed by zero bits");
endmodule

// >>> logic/shift_register_irq_logic.sv
// serial shift register with seven modes plus disabled and its interrupt flag logic
// Operation
// - external clock input: interrupt every eight bits
// - input access clears flag, restarts counter
// - capture data first cycle after clock rise
// - free-running output recirculates top bit
// - free-running output ignores bit counter
// - timer output access restarts eight shifts
// - after eight pulses stop, flag, hold data
// - system clock output shifts at half clock rate
// - external output: flag every eight pulses
// - external output access clears flag, counter
// - flags readable, write one clears flag
// - flag bit seven is active request summary
// - writing bit seven of flags does nothing
// - enable write with bit seven low clears
// - enable write with bit seven high sets
// - enable read shows bit seven as one
// - interrupt pin pulled low when request active
// - timer modes use latch low byte rate
module shift_register_irq_logic (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cs,
  input wire logic [3:0] i_rs,
  input wire logic i_rw,
  input wire logic [7:0] i_wdata,
  input wire logic [6:0] i_other_flags,
  input wire logic i_shift_clock_pin,
  input wire logic i_shift_data_pin,
  output logic [7:0] o_rdata,
  output logic o_shift_clock_pin,
  output logic o_shift_clock_pin_oe,
  output logic o_shift_data_pin,
  output logic o_shift_data_pin_oe,
  output logic o_irq_pin,
  output logic o_irq_pin_oe
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  flag_if fl ();
  logic [7:0] aux;
  logic [7:0] latch;
  logic [7:0] serial_shift_reg;
  logic [2:0] mode;
  logic [2:0] bit_count;
  logic [8:0] half_count;
  logic [8:0] next_half;
  logic running;
  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic data_meta;
  logic data_sync;
  logic ext_rise;
  logic ext_fall;
  logic int_mode;
  logic timer_mode;
  logic out_mode;
  logic tick;
  logic shift_rise;
  logic shift_fall;
  logic shift_set;
  logic bus_write;
  logic bus_read;
  logic shift_access;

  irq_flag_regs flag_regs (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .bus(fl.regs)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign mode = aux[shift_irq_pkg::MODE_MSB:shift_irq_pkg::MODE_LSB];
  assign timer_mode = (mode == shift_irq_pkg::MODE_IN_TIMER) || (mode == shift_irq_pkg::MODE_OUT_FREE) ||
                      (mode == shift_irq_pkg::MODE_OUT_TIMER);
  assign int_mode = timer_mode || (mode == shift_irq_pkg::MODE_IN_SYSCLK) ||
                    (mode == shift_irq_pkg::MODE_OUT_SYSCLK);
  assign out_mode = mode[2];
  assign bus_write = i_cs && !i_rw;
  assign bus_read = i_cs && i_rw;
  assign shift_access = i_cs && (i_rs == shift_irq_pkg::REG_SHIFT);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      clk_meta <= 1'b1;
      clk_sync <= 1'b1;
      clk_prev <= 1'b1;
    end else begin
      clk_meta <= i_shift_clock_pin;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      data_meta <= i_shift_data_pin;
      data_sync <= data_meta;
    end
  end

  assign ext_rise = clk_sync && !clk_prev;
  assign ext_fall = !clk_sync && clk_prev;

  // ----------------------------------------
  // shift clock generator
  // ----------------------------------------
  always_comb begin
    if (timer_mode) begin
      next_half = {1'b0, latch} + shift_irq_pkg::TIMER_EXTRA;
    end else begin
      next_half = shift_irq_pkg::SYSCLK_HALF;
    end
  end

  assign tick = int_mode && running && (half_count <= 9'h001);
  assign shift_rise = int_mode ? (tick && !o_shift_clock_pin) : ((mode[1:0] == 2'h3) && ext_rise);
  assign shift_fall = int_mode ? (tick && o_shift_clock_pin) : ((mode[1:0] == 2'h3) && ext_fall);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      half_count <= 9'h000;
      o_shift_clock_pin <= 1'b1;
    end else if (shift_access || !running || !int_mode) begin
      half_count <= next_half;
      o_shift_clock_pin <= 1'b1;
    end else if (tick) begin
      half_count <= next_half;
      o_shift_clock_pin <= !o_shift_clock_pin;
    end else begin
      half_count <= half_count - 9'h001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_shift_clock_pin_oe <= 1'b0;
      o_shift_data_pin_oe <= 1'b0;
    end else begin
      o_shift_clock_pin_oe <= int_mode;
      o_shift_data_pin_oe <= out_mode;
    end
  end

  // ----------------------------------------
  // run control and bit counter
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      running <= 1'b0;
    end else if (bus_write && i_rs == shift_irq_pkg::REG_AUX_CONTROL) begin
      running <= 1'b0;
    end else if (shift_access) begin
      running <= 1'b1;
    end else if (shift_rise && int_mode && bit_count == shift_irq_pkg::LAST_BIT &&
                 mode != shift_irq_pkg::MODE_OUT_FREE) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bit_count <= 3'h0;
    end else if (shift_access) begin
      bit_count <= 3'h0;
    end else if (shift_rise) begin
      bit_count <= bit_count + 3'h1;
    end
  end

  assign shift_set = shift_rise && bit_count == shift_irq_pkg::LAST_BIT &&
                     mode != shift_irq_pkg::MODE_OUT_FREE && mode != shift_irq_pkg::MODE_DISABLED;

  // ----------------------------------------
  // shift register and data pin
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      serial_shift_reg <= shift_irq_pkg::SHIFT_RESET;
    end else if (bus_write && i_rs == shift_irq_pkg::REG_SHIFT) begin
      serial_shift_reg <= i_wdata;
    end else if (!out_mode && mode != shift_irq_pkg::MODE_DISABLED && shift_rise) begin
      serial_shift_reg <= {serial_shift_reg[6:0], data_sync};
    end else if (out_mode && shift_fall) begin
      serial_shift_reg <= {serial_shift_reg[6:0], serial_shift_reg[7]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_shift_data_pin <= 1'b0;
    end else if (out_mode && shift_fall) begin
      o_shift_data_pin <= serial_shift_reg[7];
    end
  end

  // ----------------------------------------
  // control registers and flag traffic
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aux <= shift_irq_pkg::AUX_RESET;
      latch <= shift_irq_pkg::LATCH_RESET;
    end else if (bus_write && i_rs == shift_irq_pkg::REG_AUX_CONTROL) begin
      aux <= i_wdata;
    end else if (bus_write && i_rs == shift_irq_pkg::REG_TIMER_LATCH) begin
      latch <= i_wdata;
    end
  end

  always_comb begin
    fl.set_vec = i_other_flags;
    fl.set_vec[shift_irq_pkg::SHIFT_FLAG_BIT] = shift_set;
    fl.clear_vec = (bus_write && i_rs == shift_irq_pkg::REG_FLAGS) ? i_wdata[6:0] : 7'h00;
    if (shift_access || mode == shift_irq_pkg::MODE_DISABLED) begin
      fl.clear_vec[shift_irq_pkg::SHIFT_FLAG_BIT] = 1'b1;
    end
  end

  assign fl.wr_enables = bus_write && (i_rs == shift_irq_pkg::REG_ENABLES);
  assign fl.wdata = i_wdata;

  // ----------------------------------------
  // read data and interrupt pin
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (bus_read) begin
      case (i_rs)
        shift_irq_pkg::REG_SHIFT: o_rdata <= serial_shift_reg;
        shift_irq_pkg::REG_AUX_CONTROL: o_rdata <= aux;
        shift_irq_pkg::REG_FLAGS: o_rdata <= {fl.irq_any, fl.flags};
        shift_irq_pkg::REG_ENABLES: o_rdata <= {1'b1, fl.enables};
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_irq_pin <= 1'b0;
      o_irq_pin_oe <= 1'b0;
    end else begin
      o_irq_pin <= 1'b0;
      o_irq_pin_oe <= fl.irq_any;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_ext_in_flag: assert property ((mode == 3'h3 && ext_rise && bit_count == 3'h7 && !shift_access)
    |=> fl.flags[2])
    else $error("no flag after eight external input pulses");
  a_access_clears: assert property ((shift_access && !shift_set) |=> !fl.flags[2] && bit_count == 3'h0)
    else $error("shift access did not clear flag and counter");
  a_capture_edge: assert property ((mode == 3'h3 && ext_rise && !shift_access)
    |=> serial_shift_reg[0] == $past(data_sync))
    else $error("data not captured after clock rise");
  a_free_recirc: assert property ((mode == 3'h4 && shift_fall && !shift_access)
    |=> serial_shift_reg[0] == $past(serial_shift_reg[7]))
    else $error("top bit not recirculated");
  a_free_no_flag: assert property ((mode == 3'h4 && !fl.flags[2]) |=> !fl.flags[2])
    else $error("free running mode raised flag");
  a_timer_stop: assert property ((mode == 3'h5 && shift_rise && bit_count == 3'h7 && !shift_access)
    |=> !running ##1 (!running && $stable(o_shift_data_pin))[*3])
    else $error("timer output did not stop and hold");
  a_irq_pin: assert property (fl.irq_any |=> o_irq_pin_oe && !o_irq_pin)
    else $error("interrupt pin not pulled low");
  a_sysclk_rate: assert property ((mode == 3'h6 && running && !shift_access && tick)
    |=> o_shift_clock_pin != $past(o_shift_clock_pin))
    else $error("system clock output not toggling");
  a_ext_out_flag: assert property ((mode == 3'h7 && ext_rise && bit_count == 3'h7 && !shift_access)
    |=> fl.flags[2] && running == $past(running))
    else $error("external output flag missing");

  c_timer_done: cover property (mode == 3'h5 && shift_set);
  c_ext_in_done: cover property (mode == 3'h3 && shift_set);
  c_free_run: cover property (mode == 3'h4 && shift_fall);
  c_irq_active: cover property (o_irq_pin_oe);
endmodule

// >>> tb/ext_serial_dev.sv
// serial device model for the far side of the shift link
module ext_serial_dev (
  input wire logic i_clk_line,
  input wire logic i_data_line,
  output logic o_clk,
  output logic o_data,
  output logic [7:0] o_rx,
  output int o_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_clk = 1'b1;
    o_data = 1'b0;
  end
  // ----------------------------------------
  // capture line data on each clock rise
  // ----------------------------------------
  always @(posedge i_clk_line) begin
    o_rx <= {o_rx[6:0], i_data_line};
    o_cnt <= o_cnt + 1;
  end
  // ----------------------------------------
  // drive tasks
  // ----------------------------------------
  task automatic clr();
    o_cnt = 0;
  endtask
  task automatic set_data(input logic v);
    o_data = v;
  endtask
  task automatic frame(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      o_clk = 1'b0;
      o_data = tx[i];
      #62.5;
      o_clk = 1'b1;
      #62.5; // data held through high phase
    end
    o_data = ~o_data; // released line shows inverse level
  endtask
endmodule

// >>> tb/shift_register_irq_logic_tb.sv
// self-checking bench for the shift register and interrupt logic
module shift_register_irq_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_reset, i_cs, i_rw, p_clk, p_dat, clk_line, dat_line;
  logic [3:0] i_rs;
  logic [7:0] i_wdata, rdata, rx;
  logic [6:0] oflags;
  logic ck_o, ck_oe, d_o, d_oe, irq, irq_oe;
  int miscompares, check_count, cnt;
  assign clk_line = ck_oe ? ck_o : p_clk;
  assign dat_line = d_oe ? d_o : p_dat;
  shift_register_irq_logic DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_cs(i_cs), .i_rs(i_rs), .i_rw(i_rw), .i_wdata(i_wdata),
    .i_other_flags(oflags), .i_shift_clock_pin(clk_line), .i_shift_data_pin(dat_line),
    .o_rdata(rdata), .o_shift_clock_pin(ck_o), .o_shift_clock_pin_oe(ck_oe),
    .o_shift_data_pin(d_o), .o_shift_data_pin_oe(d_oe), .o_irq_pin(irq), .o_irq_pin_oe(irq_oe)
  );
  ext_serial_dev u_dev (
    .i_clk_line(clk_line), .i_data_line(dat_line), .o_clk(p_clk), .o_data(p_dat), .o_rx(rx), .o_cnt(cnt)
  );
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // compare, access and wait tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic rw, input logic [3:0] rs, input logic [7:0] wd);
    i_cs = 1'b1;
    i_rw = rw;
    i_rs = rs;
    i_wdata = wd;
    @(posedge i_clk);
    #1;
    i_cs = 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] rs, input logic [7:0] wd);
    acc(1'b0, rs, wd);
  endtask
  task automatic rd(input logic [3:0] rs, input logic [7:0] exp, input string name);
    acc(1'b1, rs, 8'h00);
    chk(name, exp, rdata);
  endtask
  task automatic wait_irq();
    int n = 0;
    while (irq_oe !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (irq_oe !== 1'b1) begin
      miscompares++;
      $display("BAD irq wait expected 1 seen %b", irq_oe);
      end_sim();
    end
  endtask
  task automatic wait_cnt(input int t);
    int n = 0;
    while (cnt < t && n < 400) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("pulse count", 8'(t), 8'(cnt));
  endtask
  task automatic pulse_other(input logic [6:0] v);
    oflags = v;
    @(posedge i_clk);
    #1;
    oflags = 7'h00;
  endtask
  task automatic send(input logic [7:0] tx);
    u_dev.frame(tx);
    @(posedge i_clk);
    #1;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_reset = 1'b1;
    i_cs = 1'b0;
    i_rw = 1'b1;
    i_rs = 4'h0;
    i_wdata = 8'h00;
    oflags = 7'h00;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    rd(4'hD, 8'h00, "flags reset");
    rd(4'hE, 8'h80, "enables reset");
    rd(4'h3, 8'h00, "unmapped");
    wr(4'hE, 8'hFF);
    rd(4'hE, 8'hFF, "enables set");
    wr(4'hE, 8'h05);
    rd(4'hE, 8'hFA, "enables clear");
    wr(4'hE, 8'h7F);
    rd(4'hE, 8'h80, "enables none");
    pulse_other(7'h05);
    rd(4'hD, 8'h01, "flag set");
    wr(4'hE, 8'h81);
    rd(4'hD, 8'h81, "summary");
    chk("irq active", 8'h01, {7'h00, irq_oe});
    chk("irq level", 8'h00, {7'h00, irq});
    wr(4'hD, 8'h80);
    rd(4'hD, 8'h81, "bit7 write");
    wr(4'hD, 8'h01);
    rd(4'hD, 8'h00, "flag cleared");
    chk("irq idle", 8'h00, {7'h00, irq_oe});
    pulse_other(7'h08);
    wr(4'hE, 8'h88);
    rd(4'hD, 8'h88, "summary two");
    wr(4'hE, 8'h08);
    rd(4'hD, 8'h08, "summary off");
    wr(4'hD, 8'h08);
    wr(4'h8, 8'h01);
    wr(4'hB, 8'h14);
    wr(4'hE, 8'h84);
    u_dev.clr();
    wr(4'hA, 8'hC5);
    wait_irq();
    chk("timer out byte", 8'hC5, rx);
    repeat (30) @(posedge i_clk);
    #1;
    chk("stopped pulses", 8'h08, 8'(cnt));
    chk("held data", 8'h01, {7'h00, dat_line});
    rd(4'hD, 8'h84, "shift flag");
    u_dev.clr();
    rd(4'hA, 8'hC5, "rotated byte");
    rd(4'hD, 8'h00, "flag restart");
    wait_irq();
    chk("repeat byte", 8'hC5, rx);
    wr(4'hB, 8'h18);
    u_dev.clr();
    wr(4'hA, 8'h3C);
    wait_irq();
    chk("sysclk byte", 8'h3C, rx);
    chk("sysclk pulses", 8'h08, 8'(cnt));
    wr(4'hB, 8'h10);
    u_dev.clr();
    wr(4'hA, 8'h96);
    wait_cnt(16);
    chk("free run byte", 8'h96, rx);
    rd(4'hD, 8'h00, "free run flag");
    wr(4'hB, 8'h00);
    rd(4'hD, 8'h00, "disabled flag");
    u_dev.set_data(1'b1);
    for (int m = 1; m <= 2; m++) begin
      wr(4'hB, 8'(m << 2));
      wr(4'hA, 8'h00);
      wait_irq();
      rd(4'hA, 8'hFF, "shift in byte");
    end
    wr(4'hB, 8'h0C);
    wr(4'hA, 8'h00);
    send(8'hA5);
    wait_irq();
    rd(4'hD, 8'h84, "ext in flag");
    rd(4'hA, 8'hA5, "ext in byte");
    rd(4'hD, 8'h00, "ext in cleared");
    send(8'h5A);
    wait_irq();
    send(8'h3C);
    rd(4'hA, 8'h3C, "no halt byte");
    wr(4'hB, 8'h1C);
    wr(4'hA, 8'hE1);
    rd(4'hD, 8'h00, "ext out cleared");
    send(8'h00);
    wait_irq();
    chk("ext out byte", 8'hE1, rx);
    rd(4'hD, 8'h84, "ext out flag");
    wr(4'hA, 8'h5B);
    rd(4'hD, 8'h00, "reload cleared");
    send(8'h00);
    chk("reload byte", 8'h5B, rx);
    end_sim();
  end
endmodule
